/* File: src/cs_decode_pkg.sv */
// shared constants for the paged swap chip select decoder
package cs_decode_pkg;

	// ***********************************************
	// page register layout
	// ***********************************************
	localparam int PAGE_REG_W = 8;
	localparam int PAGE_NUM_W = 3;
	localparam int SWAP_BIT = 7;
	localparam int UNLOCK_BIT = 6;
	localparam logic [7:0] PAGE_REG_RESET = 8'h00;
	localparam logic [2:0] LOADER_PAGE = 3'h3;

	// ***********************************************
	// register port offsets
	// ***********************************************
	localparam int REG_ADDR_W = 2;
	localparam logic [1:0] PAGE_SELECT_OFFSET = 2'h0;
	localparam logic [1:0] SELECT_STATUS_OFFSET = 2'h1;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// status register field positions
	localparam int STAT_SEVEN_BIT = 0;
	localparam int STAT_LOW_BIT = 1;
	localparam int STAT_HIGH_BIT = 2;

	// ***********************************************
	// host address windows (64 Kbyte space)
	// ***********************************************
	localparam int HOST_ADDR_W = 16;
	localparam logic [15:0] BOOT_LOW_START = 16'hC000;
	localparam logic [15:0] BOOT_LOW_END = 16'hDFFF;
	localparam logic [15:0] BOOT_HIGH_START = 16'hE000;
	localparam logic [15:0] BOOT_HIGH_END = 16'hFFFF;
	localparam logic [15:0] LOADER_LOW_START = 16'h4000;
	localparam logic [15:0] LOADER_LOW_END = 16'h5FFF;
	localparam logic [15:0] LOADER_HIGH_START = 16'h6000;
	localparam logic [15:0] LOADER_HIGH_END = 16'h7FFF;

	// number of address windows checked in parallel
	localparam int NUM_WINDOWS = 4;
	localparam int WIN_BOOT_LOW = 0;
	localparam int WIN_BOOT_HIGH = 1;
	localparam int WIN_LOAD_LOW = 2;
	localparam int WIN_LOAD_HIGH = 3;

endpackage

/* File: src/addr_window_match.sv */
// inclusive address window comparator
`timescale 1ns/1ps
module addr_window_match #(
	parameter int ADDR_W = 16
) (
	input wire logic [ADDR_W-1:0] addr, // host address
	input wire logic [ADDR_W-1:0] lo, // first address of window
	input wire logic [ADDR_W-1:0] hi, // last address of window
	output logic hit // address inside window
);

	// plain magnitude compare, both ends inclusive
	assign hit = (addr >= lo) && (addr <= hi);

endmodule

/* File: src/page_select_reg.sv */
// page select register with synchronous clear
`timescale 1ns/1ps
module page_select_reg #(
	parameter int WIDTH = 8
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic wr_en, // load strobe
	input wire logic [WIDTH-1:0] wdata, // value to load
	output logic [WIDTH-1:0] q // held value
);

	logic [WIDTH-1:0] page_r;
	logic [WIDTH-1:0] page_nxt;

	// hold unless loaded
	assign page_nxt = wr_en ? wdata : page_r;

	// every bit clears so the boot map comes up first
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			page_r <= WIDTH'(cs_decode_pkg::PAGE_REG_RESET);
		end else begin
			page_r <= page_nxt;
		end
	end

	assign q = page_r;

endmodule

/* File: src/paged_swap_chip_select_decoder.sv */
// chip select decoder with page register, boot swap and loader unlock
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module paged_swap_chip_select_decoder (
	input wire logic mclk, // 10 MHz system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [15:0] host_addr, // host address bus
	input wire logic [1:0] reg_addr, // register port address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	output logic [2:0] page_number, // current page number
	output logic main_flash_seg_seven, // main flash segment 7 select
	output logic secondary_flash_low_select, // lower secondary select
	output logic secondary_flash_high_select // upper secondary select
);

	// ***********************************************
	// register port decode
	// ***********************************************
	logic page_wr;
	logic [7:0] page_q;
	logic [7:0] status_word;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic hit_page;
	logic hit_status;

	// address decode of the two mapped words
	assign hit_page = reg_addr == cs_decode_pkg::PAGE_SELECT_OFFSET;
	assign hit_status = reg_addr == cs_decode_pkg::SELECT_STATUS_OFFSET;
	assign page_wr = reg_wr && hit_page;

	page_select_reg #(
		.WIDTH(cs_decode_pkg::PAGE_REG_W)
	) u_page (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr_en(page_wr),
		.wdata(reg_wdata),
		.q(page_q)
	);

	// ***********************************************
	// page register fields
	// ***********************************************
	logic page_reg_top_bit;
	logic page_reg_second_top_bit;
	logic [2:0] page_num;

	// paging bits from the bottom, logic bits from the top
	assign page_num = page_q[cs_decode_pkg::PAGE_NUM_W-1:0];
	assign page_reg_top_bit = page_q[cs_decode_pkg::SWAP_BIT];
	assign page_reg_second_top_bit = page_q[cs_decode_pkg::UNLOCK_BIT];
	assign page_number = page_num;

	// ***********************************************
	// address windows
	// ***********************************************
	logic [15:0] win_lo [cs_decode_pkg::NUM_WINDOWS];
	logic [15:0] win_hi [cs_decode_pkg::NUM_WINDOWS];
	logic [cs_decode_pkg::NUM_WINDOWS-1:0] win_hit;

	// window bounds table
	assign win_lo[cs_decode_pkg::WIN_BOOT_LOW] =
		cs_decode_pkg::BOOT_LOW_START;
	assign win_hi[cs_decode_pkg::WIN_BOOT_LOW] = cs_decode_pkg::BOOT_LOW_END;
	assign win_lo[cs_decode_pkg::WIN_BOOT_HIGH] =
		cs_decode_pkg::BOOT_HIGH_START;
	assign win_hi[cs_decode_pkg::WIN_BOOT_HIGH] =
		cs_decode_pkg::BOOT_HIGH_END;
	assign win_lo[cs_decode_pkg::WIN_LOAD_LOW] =
		cs_decode_pkg::LOADER_LOW_START;
	assign win_hi[cs_decode_pkg::WIN_LOAD_LOW] =
		cs_decode_pkg::LOADER_LOW_END;
	assign win_lo[cs_decode_pkg::WIN_LOAD_HIGH] =
		cs_decode_pkg::LOADER_HIGH_START;
	assign win_hi[cs_decode_pkg::WIN_LOAD_HIGH] =
		cs_decode_pkg::LOADER_HIGH_END;

	// one comparator per window
	for (genvar i = 0; i < cs_decode_pkg::NUM_WINDOWS; i++) begin : g_win
		addr_window_match #(
			.ADDR_W(cs_decode_pkg::HOST_ADDR_W)
		) u_match (
			.addr(host_addr),
			.lo(win_lo[i]),
			.hi(win_hi[i]),
			.hit(win_hit[i])
		);
	end

	// ***********************************************
	// chip select equations
	// ***********************************************
	logic boot_area;
	logic loader_open;
	logic low_boot_term;
	logic high_boot_term;
	logic low_load_term;
	logic high_load_term;

	// selects are pure decode so the host sees them in the same cycle
	assign boot_area = win_hit[cs_decode_pkg::WIN_BOOT_LOW] ||
		win_hit[cs_decode_pkg::WIN_BOOT_HIGH];
	// loader reachable only after swap, on its page, and when unlocked
	assign loader_open = page_reg_top_bit && page_reg_second_top_bit &&
		(page_num == cs_decode_pkg::LOADER_PAGE);
	// boot terms ignore page number entirely
	assign low_boot_term = !page_reg_top_bit &&
		win_hit[cs_decode_pkg::WIN_BOOT_LOW];
	assign high_boot_term = !page_reg_top_bit &&
		win_hit[cs_decode_pkg::WIN_BOOT_HIGH];
	assign low_load_term = loader_open &&
		win_hit[cs_decode_pkg::WIN_LOAD_LOW];
	assign high_load_term = loader_open &&
		win_hit[cs_decode_pkg::WIN_LOAD_HIGH];
	assign secondary_flash_low_select = low_boot_term || low_load_term;
	assign secondary_flash_high_select =
		high_boot_term || high_load_term;
	// segment seven takes the boot area only while swapped
	assign main_flash_seg_seven = page_reg_top_bit && boot_area;

	// ***********************************************
	// register read path
	// ***********************************************
	// status shows live selects for the current host address
	assign status_word = {5'h00,
		secondary_flash_high_select,
		secondary_flash_low_select,
		main_flash_seg_seven};

	// unmapped reads return zero; data stand only in the cycle after
	assign rdata_nxt = !reg_rd ? cs_decode_pkg::UNMAPPED_READ :
		hit_page ? page_q :
		hit_status ? status_word : cs_decode_pkg::UNMAPPED_READ;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_r <= cs_decode_pkg::UNMAPPED_READ;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ***********************************************
	// checks
	// ***********************************************
	logic in_boot_low;
	logic in_boot_high;
	logic in_boot_any;
	logic in_load_low;
	logic in_load_high;
	logic on_loader_page;

	// inclusive window test, kept apart from the comparator instances
	// so that a wrong bound in the table above is still caught
	function automatic logic in_window(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_window = (a >= lo) && (a <= hi);
	endfunction

	// reference windows restated from the package constants
	assign in_boot_low = in_window(host_addr,
		cs_decode_pkg::BOOT_LOW_START,
		cs_decode_pkg::BOOT_LOW_END);
	assign in_boot_high = in_window(host_addr,
		cs_decode_pkg::BOOT_HIGH_START,
		cs_decode_pkg::BOOT_HIGH_END);
	assign in_boot_any = in_boot_low || in_boot_high;
	assign in_load_low = in_window(host_addr,
		cs_decode_pkg::LOADER_LOW_START,
		cs_decode_pkg::LOADER_LOW_END);
	assign in_load_high = in_window(host_addr,
		cs_decode_pkg::LOADER_HIGH_START,
		cs_decode_pkg::LOADER_HIGH_END);
	assign on_loader_page = page_number == cs_decode_pkg::LOADER_PAGE;

	// one clock domain, so every check shares the clock, and all but chk_reset_clears share the reset
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ***********************************************
	// register port and page field checks
	// ***********************************************

	chk_page_number_load: assert property (
		page_wr |=> page_number == $past(reg_wdata[2:0]))
		else $error("page number not loaded from low bits");

	chk_swap_top_bit: assert property (
		page_wr ##1 in_boot_any |-> main_flash_seg_seven == $past(reg_wdata[7]))
		else $error("swap not taken from top page bit");

	chk_unlock_second_bit: assert property (
		page_wr && reg_wdata[7] && reg_wdata[2:0] == 3'h3 ##1 in_load_low
		|-> secondary_flash_low_select == $past(reg_wdata[6]))
		else $error("unlock not taken from second top bit");

	chk_lock_blocks_loader: assert property (
		!page_reg_second_top_bit && page_reg_top_bit
		|-> !secondary_flash_low_select && !secondary_flash_high_select)
		else $error("secondary select while locked");

	chk_boot_low_select: assert property (
		!page_reg_top_bit && in_boot_low |-> secondary_flash_low_select)
		else $error("boot area lower select missing");

	chk_loader_low_window: assert property (
		page_reg_top_bit && page_reg_second_top_bit && on_loader_page &&
		in_load_low |-> secondary_flash_low_select)
		else $error("loader window lower select missing");

	chk_boot_all_pages: assert property (
		!page_reg_top_bit && in_boot_any
		|-> secondary_flash_low_select ^ secondary_flash_high_select)
		else $error("boot area decode depends on page");

	chk_swap_exchange: assert property (
		page_reg_top_bit && in_boot_any |-> main_flash_seg_seven &&
		!secondary_flash_low_select && !secondary_flash_high_select)
		else $error("swap did not exchange boot area");

	chk_no_overlap: assert property (
		!(main_flash_seg_seven &&
		(secondary_flash_low_select || secondary_flash_high_select)))
		else $error("two segments selected at once");

	// reset is the trigger here, so the default disable must not apply
	chk_reset_clears: assert property (
		@(posedge mclk) disable iff (1'b0)
		!rst_n |=> page_q == cs_decode_pkg::PAGE_REG_RESET)
		else $error("page register not cleared by reset");

	chk_read_timing: assert property (
		reg_rd && hit_page && !page_wr |=> reg_rdata == $past(page_q))
		else $error("page register readback wrong");

	// read data must fall back to zero, or a stale word looks like a read
	chk_read_idle_zero: assert property (
		!reg_rd |=> reg_rdata == cs_decode_pkg::UNMAPPED_READ)
		else $error("read data not cleared after read cycle");

	// the status word and unmapped offsets must never touch the page
	chk_offset_write_ignored: assert property (
		reg_wr && !hit_page |=> page_q == $past(page_q))
		else $error("page register changed by other offset");

	// ***********************************************
	// select decode completeness
	// ***********************************************
	chk_boot_high_select: assert property (
		!page_reg_top_bit && in_boot_high |-> secondary_flash_high_select)
		else $error("boot area upper select missing");

	chk_loader_high_window: assert property (
		page_reg_top_bit && page_reg_second_top_bit && on_loader_page &&
		in_load_high |-> secondary_flash_high_select)
		else $error("loader window upper select missing");

	// loader window must vanish on every other page
	chk_loader_page_only: assert property (
		!on_loader_page && !in_boot_any
		|-> !secondary_flash_low_select && !secondary_flash_high_select)
		else $error("loader window open on wrong page");

	// segment seven belongs to another map while unswapped
	chk_seven_unswapped_off: assert property (
		!page_reg_top_bit |-> !main_flash_seg_seven)
		else $error("segment seven selected while unswapped");

	// addresses outside the four windows never reach these segments
	chk_outside_windows_quiet: assert property (
		!in_boot_any && !in_load_low && !in_load_high
		|-> !main_flash_seg_seven && !secondary_flash_low_select &&
		!secondary_flash_high_select)
		else $error("select outside its address windows");

	// ***********************************************
	// cover points for the main scenarios
	// ***********************************************
	cov_boot_fetch: cover property (!page_reg_top_bit && in_boot_low);
	cov_swap_set: cover property (page_wr && reg_wdata[7] ##1 in_boot_any);
	cov_loader_write: cover property (loader_open && in_load_low);
	cov_relocked_loader: cover property (page_reg_top_bit &&
		!page_reg_second_top_bit && in_load_low);
	cov_status_read: cover property (reg_rd && hit_status);

endmodule

/* File: verif/host_model.sv */
// host microcontroller model: register port master and address bus
`timescale 1ns/1ps
module host_model (
	input wire logic mclk, // system clock
	output logic [15:0] host_addr, // host address bus
	output logic [1:0] reg_addr, // register port address
	output logic [7:0] reg_wdata, // register write data
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata // read data
);
	// idle bus from time zero
	initial begin
		host_addr = 16'h0000;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one-cycle write; returns once the loaded value has settled,
	// so callers never sample in the edge that launches it
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		#10;
	endtask

	// one-cycle read; data sampled once settled in the cycle after
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#10;
		d = reg_rdata;
	endtask

	// selects are combinational, so a short settle is enough
	task automatic put_addr(input logic [15:0] a);
		@(posedge mclk);
		host_addr <= a;
		#10;
	endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the paged swap chip select decoder
`timescale 1ns/1ps
module testbench;
	logic mclk;
	logic rst_n;
	logic [15:0] host_addr;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, seven, low, high;
	logic [2:0] page_number;
	int miscompares = 0;
	int check_count = 0;

	host_model host_u (.mclk(mclk), .host_addr(host_addr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	paged_swap_chip_select_decoder dut_u (.mclk(mclk), .rst_n(rst_n),
		.host_addr(host_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.page_number(page_number), .main_flash_seg_seven(seven),
		.secondary_flash_low_select(low), .secondary_flash_high_select(high));

	// ***********************************************
	// clock, checking helpers and closing report
	// ***********************************************
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// expected order is seven, low, high
	task automatic sel(input logic [15:0] a, input logic [2:0] e);
		host_u.put_addr(a);
		chk("selects", {5'h00, e}, {5'h00, seven, low, high});
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ***********************************************
	// scenarios
	// ***********************************************
	// boot map straight out of reset
	task automatic t_reset();
		host_u.rd(cs_decode_pkg::PAGE_SELECT_OFFSET, d);
		chk("page reg", 8'h00, d);
		chk("page number", 8'h00, {5'h00, page_number});
		sel(16'hC000, 3'b010);
		sel(16'hE000, 3'b001);
		sel(16'h4000, 3'b000);
		$display("test reset done");
	endtask

	// boot area identical on all pages, unlock alone changes nothing
	task automatic t_pages();
		for (int p = 0; p < 8; p++) begin
			host_u.wr(2'h0, {1'b0, p[0], 3'h0, p[2:0]});
			chk("page number", {5'h00, p[2:0]}, {5'h00, page_number});
			sel(16'hDFFF, 3'b010);
			sel(16'hFFFF, 3'b001);
		end
		$display("test pages done");
	endtask

	// swap moves segment seven into the boot area; locked loader stays off
	task automatic t_swap();
		host_u.wr(2'h0, 8'h80);
		sel(16'hC000, 3'b100);
		sel(16'hFFFF, 3'b100);
		host_u.wr(2'h0, 8'h83);
		sel(16'h4000, 3'b000);
		sel(16'h6000, 3'b000);
		$display("test swap done");
	endtask

	// loader window needs page 3, swap and unlock together
	task automatic t_loader();
		host_u.wr(2'h0, 8'hC3);
		chk("page number", 8'h03, {5'h00, page_number});
		sel(16'h4000, 3'b010);
		sel(16'h5FFF, 3'b010);
		sel(16'h6000, 3'b001);
		sel(16'h3FFF, 3'b000);
		sel(16'hDFFF, 3'b100);
		host_u.wr(2'h0, 8'hC2);
		sel(16'h4000, 3'b000);
		// unlock and relock while the address sits in the loader window
		host_u.wr(2'h0, 8'hC3);
		sel(16'h4000, 3'b010);
		host_u.wr(2'h0, 8'h83);
		sel(16'h4000, 3'b000);
		host_u.wr(2'h0, 8'h43);
		sel(16'h4000, 3'b000);
		sel(16'hC000, 3'b010);
		$display("test loader done");
	endtask

	// register port odd cases, then a reset in mid-run with swap set
	task automatic t_regs();
		host_u.wr(2'h0, 8'hA5);
		host_u.wr(cs_decode_pkg::SELECT_STATUS_OFFSET, 8'hFF);
		host_u.rd(2'h0, d);
		chk("page reg", 8'hA5, d);
		@(posedge mclk);
		#10;
		chk("rdata after", 8'h00, reg_rdata);
		host_u.rd(2'h2, d);
		chk("unmapped", cs_decode_pkg::UNMAPPED_READ, d);
		host_u.wr(2'h0, 8'h00);
		host_u.put_addr(16'hC000);
		host_u.rd(cs_decode_pkg::SELECT_STATUS_OFFSET, d);
		chk("status", 8'h02, d);
		host_u.wr(2'h0, 8'hC3);
		do_reset();
		host_u.rd(2'h0, d);
		chk("page reg", 8'h00, d);
		sel(16'hC000, 3'b010);
		$display("test regs done");
	endtask

	// ***********************************************
	// main sequence and watchdog
	// ***********************************************
	initial begin
		rst_n = 1'b0;
		do_reset();
		t_reset();
		t_pages();
		t_swap();
		t_loader();
		t_regs();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		$display("BAD run_length expected done seen timeout");
		end_of_test();
	end
endmodule
